/* File: core/dcs_pkg.sv */
// constants, field layout and carrier types of the channel control block
// assumes one sample clock and a synchronous active-high reset
package dcs_pkg;
   localparam int unsigned DATA_W = 20;
   // channel address map
   localparam logic [7:0] ADR_SLEEP = 8'h80;
   localparam logic [7:0] ADR_SOFT  = 8'h81;
   localparam logic [7:0] ADR_PIN   = 8'h82;
   localparam logic [7:0] ADR_START = 8'h83;
   localparam logic [7:0] ADR_HOP   = 8'h84;
   localparam logic [7:0] ADR_TWL   = 8'h85;
   localparam logic [7:0] ADR_TWH   = 8'h86;
   localparam logic [7:0] ADR_PHASE = 8'h87;
   localparam logic [7:0] ADR_OSC   = 8'h88;
   localparam logic [7:0] ADR_RDEC  = 8'h90;
   localparam logic [7:0] ADR_RINT  = 8'h91;
   localparam logic [7:0] ADR_RSCL  = 8'h92;
   localparam logic [7:0] ADR_RSVA  = 8'h93;
   localparam logic [7:0] ADR_CDEC  = 8'h94;
   localparam logic [7:0] ADR_CSCL  = 8'h95;
   localparam logic [7:0] ADR_RSVB  = 8'h96;
   localparam logic [7:0] ADR_FDEC  = 8'ha0;
   localparam logic [7:0] ADR_FPH   = 8'ha1;
   localparam logic [7:0] ADR_FTAP  = 8'ha2;
   localparam logic [7:0] ADR_FOFF  = 8'ha3;
   localparam logic [7:0] ADR_FCTL  = 8'ha4;
   localparam logic [7:0] ADR_SIGI  = 8'ha5;
   localparam logic [7:0] ADR_SIGQ  = 8'ha6;
   localparam logic [7:0] ADR_SCNT  = 8'ha7;
   localparam logic [7:0] ADR_MBST  = 8'ha8;
   localparam logic [7:0] ADR_OCTL  = 8'ha9;
   // field positions
   localparam int unsigned SOFT_START = 0;
   localparam int unsigned SOFT_HOP   = 1;
   localparam int unsigned PIN_ST_EN  = 0;
   localparam int unsigned PIN_HOP_EN = 1;
   localparam int unsigned PIN_FIRST  = 2;
   localparam int unsigned OSC_BYPASS = 0;
   localparam int unsigned OSC_PDITH  = 1;
   localparam int unsigned OSC_ADITH  = 2;
   localparam int unsigned OSC_CLR    = 3;
   localparam int unsigned OSC_INSEL  = 6;
   localparam int unsigned OSC_SYNC_L = 7;
   localparam int unsigned RSC_ACT_L  = 5;
   localparam int unsigned FCTL_BANK  = 8;
   localparam int unsigned FCTL_SRC   = 9;
   localparam int unsigned FCTL_FMT_L = 4;
   localparam int unsigned OCTL_WIDE  = 5;
   localparam int unsigned OCTL_MAP   = 9;
   localparam int unsigned MB_EN      = 0;
   localparam int unsigned MB_CRAM    = 1;
   localparam int unsigned MB_DRAM    = 2;
   // values after reset and counter constants
   localparam logic        RST_SLEEP  = 1'b1;
   localparam logic [15:0] HOLD_ONE   = 16'h0001;
   localparam logic [15:0] HOLD_OFF   = 16'h0000;
   localparam logic [19:0] SCNT_ZERO  = 20'h0_0000;

   typedef enum logic [1:0] {
      CNT_IDLE = 2'b01,
      CNT_RUN  = 2'b10
   } dcs_cnt_state_type;

   typedef struct packed {
      logic [7:0]  addr;
      logic [19:0] wdata;
      logic        wr;
      logic        rd;
   } dcs_acc_type;

   typedef struct packed {
      logic [15:0] phase_offset;
      logic [8:0]  osc_ctrl;
      logic [11:0] rs_dec;
      logic [8:0]  rs_int;
      logic [11:0] rs_scale;
      logic [7:0]  c5_dec;
      logic [4:0]  c5_scale;
      logic [7:0]  cf_dec;
      logic [7:0]  cf_phase;
      logic [7:0]  cf_taps;
      logic [7:0]  cf_offset;
      logic [10:0] cf_ctrl;
      logic [9:0]  out_ctrl;
      logic        mem_test_en;
   } dcs_cfg_type;
endpackage

/* File: core/dcs_channel.sv */
// channel control bank: hold-off counters, tuning word shadow, channel map
// assumes accesses arrive one cycle wide from the indirect host port logic,
// and pins sync and level indicator come from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module dcs_channel
   import dcs_pkg::*;
#(
   parameter int unsigned CRAM_DEPTH = 256
) (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire dcs_acc_type acc,
   output logic [19:0]      rd_data,
   output logic             rd_valid,
   input  wire logic        ext_sleep_wr,
   input  wire logic        ext_sleep_bit,
   input  wire logic        ext_pin_wr,
   input  wire logic [2:0]  ext_pin_bits,
   input  wire logic [3:0]  sync_pin,
   input  wire logic        level_pin,
   input  wire logic [15:0] filt_i,
   input  wire logic [15:0] filt_q,
   input  wire logic        filt_valid,
   input  wire logic        cram_pass,
   input  wire logic        dram_pass,
   input  wire logic [7:0]  coef_rd_addr,
   output logic [19:0]      coef_rd_data,
   output dcs_cfg_type      cfg,
   output logic [31:0]      tuning_word,
   output logic             channel_sleep,
   output logic             start_pulse,
   output logic             realign_pulse,
   output logic             hop_pulse,
   output logic             clear_acc_pulse,
   output logic [4:0]       scale_now,
   output logic             wide_samples,
   output logic             other_source
);
   if (CRAM_DEPTH != 256) begin : g_chk
      $error("coefficient memory must be two banks of 128 words");
   end

   // ********************************************************************
   // pin synchronisers
   // ********************************************************************
   logic [3:0] pin_s1_ff, pin_s2_ff, pin_s3_ff;
   logic       li_s1_ff, li_s2_ff;
   always_ff @(posedge clk) begin
      if (reset) begin
         pin_s1_ff <= 4'h0;
         pin_s2_ff <= 4'h0;
         pin_s3_ff <= 4'h0;
         li_s1_ff  <= 1'b0;
         li_s2_ff  <= 1'b0;
      end else begin
         pin_s1_ff <= sync_pin;
         pin_s2_ff <= pin_s1_ff;
         pin_s3_ff <= pin_s2_ff;
         li_s1_ff  <= level_pin;
         li_s2_ff  <= li_s1_ff;
      end
   end

   // ********************************************************************
   // register bank state
   // ********************************************************************
   logic              sleep_ff, nxt_sleep;
   logic [2:0]        pin_ff, nxt_pin;
   logic [15:0]       stdel_ff, nxt_stdel, hopdel_ff, nxt_hopdel;
   logic [31:0]       shadow_ff, nxt_shadow, tw_ff, nxt_tw;
   dcs_cfg_type       cfg_ff, nxt_cfg;
   logic [15:0]       sig_i_ff, nxt_sig_i, sig_q_ff, nxt_sig_q;
   logic [19:0]       scnt_ff, nxt_scnt, rd_ff, nxt_rd;
   logic              rdv_ff;
   logic              st_seen_ff, nxt_st_seen, hp_seen_ff, nxt_hp_seen;
   dcs_cnt_state_type st_state_ff, nxt_st_state, hp_state_ff, nxt_hp_state;
   logic [15:0]       st_cnt_ff, nxt_st_cnt, hp_cnt_ff, nxt_hp_cnt;
   logic              stp_ff, nxt_stp, rap_ff, nxt_rap;
   logic              hpp_ff, nxt_hpp, clp_ff, nxt_clp;
   logic [19:0]       cram [CRAM_DEPTH];
   logic [19:0]       coef_ff;

   logic       wr, pin_edge, start_trig, hop_trig, st_fire, hp_fire;
   logic [7:0] cram_idx;

   // strobe passed in so continuous users see it change
   function automatic logic hit(input dcs_acc_type x, input logic [7:0] r);
      return x.wr && (x.addr == r);
   endfunction

   assign wr = acc.wr;
   assign pin_edge = pin_s2_ff[cfg_ff.osc_ctrl[OSC_SYNC_L +: 2]]
                   & ~pin_s3_ff[cfg_ff.osc_ctrl[OSC_SYNC_L +: 2]];
   assign start_trig = (hit(acc, ADR_SOFT) && acc.wdata[SOFT_START])
                     | (pin_edge && pin_ff[PIN_ST_EN]
                        && !(pin_ff[PIN_FIRST] && st_seen_ff));
   assign hop_trig   = (hit(acc, ADR_SOFT) && acc.wdata[SOFT_HOP])
                     | (pin_edge && pin_ff[PIN_HOP_EN]
                        && !(pin_ff[PIN_FIRST] && hp_seen_ff));
   assign st_fire = (st_state_ff == CNT_RUN) && (st_cnt_ff == HOLD_ONE);
   assign hp_fire = (hp_state_ff == CNT_RUN) && (hp_cnt_ff == HOLD_ONE);
   assign cram_idx = {cfg_ff.cf_ctrl[FCTL_BANK], acc.addr[6:0]};

   // ********************************************************************
   // hold-off counters
   // ********************************************************************
   always_comb begin
      nxt_st_state = st_state_ff;
      nxt_st_cnt   = st_cnt_ff;
      nxt_hp_state = hp_state_ff;
      nxt_hp_cnt   = hp_cnt_ff;
      nxt_st_seen  = st_seen_ff;
      nxt_hp_seen  = hp_seen_ff;
      unique case (st_state_ff)
         CNT_IDLE: ;
         CNT_RUN: begin
            if (st_cnt_ff == HOLD_ONE) begin
               nxt_st_state = CNT_IDLE;
            end else begin
               nxt_st_cnt = st_cnt_ff - HOLD_ONE;
            end
         end
         default: nxt_st_state = CNT_IDLE;
      endcase
      unique case (hp_state_ff)
         CNT_IDLE: ;
         CNT_RUN: begin
            if (hp_cnt_ff == HOLD_ONE) begin
               nxt_hp_state = CNT_IDLE;
            end else begin
               nxt_hp_cnt = hp_cnt_ff - HOLD_ONE;
            end
         end
         default: nxt_hp_state = CNT_IDLE;
      endcase
      if (start_trig && stdel_ff != HOLD_OFF) begin
         nxt_st_state = CNT_RUN;
         nxt_st_cnt   = stdel_ff;
      end
      if (hop_trig && hopdel_ff != HOLD_OFF) begin
         nxt_hp_state = CNT_RUN;
         nxt_hp_cnt   = hopdel_ff;
      end
      // first-sync-only memory rearms when routing is rewritten
      if (hit(acc, ADR_PIN) || ext_pin_wr) begin
         nxt_st_seen = 1'b0;
         nxt_hp_seen = 1'b0;
      end
      if (pin_edge && pin_ff[PIN_ST_EN]) begin
         nxt_st_seen = 1'b1;
      end
      if (pin_edge && pin_ff[PIN_HOP_EN]) begin
         nxt_hp_seen = 1'b1;
      end
   end

   // ********************************************************************
   // register bank next state
   // ********************************************************************
   always_comb begin
      nxt_sleep  = sleep_ff;
      nxt_pin    = pin_ff;
      nxt_stdel  = stdel_ff;
      nxt_hopdel = hopdel_ff;
      nxt_shadow = shadow_ff;
      nxt_tw     = tw_ff;
      nxt_cfg    = cfg_ff;
      nxt_sig_i  = sig_i_ff;
      nxt_sig_q  = sig_q_ff;
      nxt_scnt   = scnt_ff;
      nxt_stp    = 1'b0;
      nxt_rap    = 1'b0;
      nxt_hpp    = 1'b0;
      nxt_clp    = 1'b0;
      if (wr) begin
         unique case (acc.addr)
            ADR_SLEEP: nxt_sleep  = acc.wdata[0];
            ADR_PIN:   nxt_pin    = acc.wdata[2:0];
            ADR_START: nxt_stdel  = acc.wdata[15:0];
            ADR_HOP:   nxt_hopdel = acc.wdata[15:0];
            ADR_TWL:   nxt_shadow[15:0]  = acc.wdata[15:0];
            ADR_TWH:   nxt_shadow[31:16] = acc.wdata[15:0];
            ADR_PHASE: nxt_cfg.phase_offset = acc.wdata[15:0];
            ADR_OSC:   nxt_cfg.osc_ctrl = acc.wdata[8:0];
            ADR_RDEC:  nxt_cfg.rs_dec   = acc.wdata[11:0];
            ADR_RINT:  nxt_cfg.rs_int   = acc.wdata[8:0];
            ADR_RSCL:  nxt_cfg.rs_scale = acc.wdata[11:0];
            ADR_CDEC:  nxt_cfg.c5_dec   = acc.wdata[7:0];
            ADR_CSCL:  nxt_cfg.c5_scale = acc.wdata[4:0];
            ADR_FDEC:  nxt_cfg.cf_dec   = acc.wdata[7:0];
            ADR_FPH:   nxt_cfg.cf_phase = acc.wdata[7:0];
            ADR_FTAP:  nxt_cfg.cf_taps  = acc.wdata[7:0];
            ADR_FOFF:  nxt_cfg.cf_offset = acc.wdata[7:0];
            ADR_FCTL:  nxt_cfg.cf_ctrl  = acc.wdata[10:0];
            ADR_SIGI:  nxt_sig_i = acc.wdata[15:0];
            ADR_SIGQ:  nxt_sig_q = acc.wdata[15:0];
            ADR_SCNT:  nxt_scnt  = acc.wdata[19:0];
            ADR_MBST:  nxt_cfg.mem_test_en = acc.wdata[MB_EN];
            ADR_OCTL:  nxt_cfg.out_ctrl = acc.wdata[9:0];
            default: ;
         endcase
      end
      // external sleep register presets the bit
      if (ext_sleep_wr) begin
         nxt_sleep = ext_sleep_bit;
      end
      if (ext_pin_wr) begin
         nxt_pin = ext_pin_bits;
      end
      // delay of one passes writes through
      if (hopdel_ff == HOLD_ONE
          && (hit(acc, ADR_TWL) || hit(acc, ADR_TWH))) begin
         nxt_tw = nxt_shadow;
      end
      if (hp_fire) begin
         nxt_tw  = nxt_shadow;
         nxt_hpp = 1'b1;
         nxt_clp = cfg_ff.osc_ctrl[OSC_CLR];
      end
      if (st_fire) begin
         if (sleep_ff) begin
            // wake loads working word; wins over a host write
            nxt_sleep = 1'b0;
            nxt_tw    = nxt_shadow;
            nxt_stp   = 1'b1;
         end else begin
            nxt_rap = 1'b1;
         end
      end
      if (filt_valid && !wr) begin
         if (cfg_ff.out_ctrl[OCTL_MAP]) begin
            nxt_sig_i = filt_i;
            nxt_sig_q = filt_q;
         end else if (scnt_ff != SCNT_ZERO) begin
            nxt_sig_i = {sig_i_ff[14:0], sig_i_ff[15]} ^ filt_i;
            nxt_sig_q = {sig_q_ff[14:0], sig_q_ff[15]} ^ filt_q;
            nxt_scnt  = scnt_ff - 20'h0_0001;
         end
      end
   end

   // ********************************************************************
   // read mux, unmapped and write-only read zero
   // ********************************************************************
   always_comb begin
      nxt_rd = 20'h0_0000;
      if (acc.addr <= 8'h7f) begin
         nxt_rd = cram[cram_idx];
      end else begin
         unique case (acc.addr)
            ADR_SLEEP: nxt_rd = {19'h0_0000, sleep_ff};
            ADR_PIN:   nxt_rd = {17'h0_0000, pin_ff};
            ADR_START: nxt_rd = {4'h0, stdel_ff};
            ADR_HOP:   nxt_rd = {4'h0, hopdel_ff};
            ADR_TWL:   nxt_rd = {4'h0, shadow_ff[15:0]};
            ADR_TWH:   nxt_rd = {4'h0, shadow_ff[31:16]};
            ADR_PHASE: nxt_rd = {4'h0, cfg_ff.phase_offset};
            ADR_OSC:   nxt_rd = {11'h000, cfg_ff.osc_ctrl};
            ADR_RDEC:  nxt_rd = {8'h00, cfg_ff.rs_dec};
            ADR_RINT:  nxt_rd = {11'h000, cfg_ff.rs_int};
            ADR_RSCL:  nxt_rd = {8'h00, cfg_ff.rs_scale};
            ADR_CDEC:  nxt_rd = {12'h000, cfg_ff.c5_dec};
            ADR_CSCL:  nxt_rd = {15'h0000, cfg_ff.c5_scale};
            ADR_FDEC:  nxt_rd = {12'h000, cfg_ff.cf_dec};
            ADR_FPH:   nxt_rd = {12'h000, cfg_ff.cf_phase};
            ADR_FTAP:  nxt_rd = {12'h000, cfg_ff.cf_taps};
            ADR_FOFF:  nxt_rd = {12'h000, cfg_ff.cf_offset};
            ADR_FCTL:  nxt_rd = {9'h000, cfg_ff.cf_ctrl};
            ADR_SIGI:  nxt_rd = {4'h0, sig_i_ff};
            ADR_SIGQ:  nxt_rd = {4'h0, sig_q_ff};
            ADR_SCNT:  nxt_rd = scnt_ff;
            // pass flags from the memory test engine
            ADR_MBST:  nxt_rd = {17'h0_0000, dram_pass, cram_pass,
                                 cfg_ff.mem_test_en};
            ADR_OCTL:  nxt_rd = {10'h000, cfg_ff.out_ctrl};
            default:   nxt_rd = 20'h0_0000;
         endcase
      end
   end

   // ********************************************************************
   // state registers
   // ********************************************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         sleep_ff    <= RST_SLEEP;
         pin_ff      <= 3'h0;
         stdel_ff    <= HOLD_OFF;
         hopdel_ff   <= HOLD_OFF;
         shadow_ff   <= 32'h0000_0000;
         tw_ff       <= 32'h0000_0000;
         cfg_ff      <= '0;
         sig_i_ff    <= 16'h0000;
         sig_q_ff    <= 16'h0000;
         scnt_ff     <= SCNT_ZERO;
         rd_ff       <= 20'h0_0000;
         rdv_ff      <= 1'b0;
         st_seen_ff  <= 1'b0;
         hp_seen_ff  <= 1'b0;
         st_state_ff <= CNT_IDLE;
         hp_state_ff <= CNT_IDLE;
         st_cnt_ff   <= HOLD_OFF;
         hp_cnt_ff   <= HOLD_OFF;
         stp_ff      <= 1'b0;
         rap_ff      <= 1'b0;
         hpp_ff      <= 1'b0;
         clp_ff      <= 1'b0;
      end else begin
         sleep_ff    <= nxt_sleep;
         pin_ff      <= nxt_pin;
         stdel_ff    <= nxt_stdel;
         hopdel_ff   <= nxt_hopdel;
         shadow_ff   <= nxt_shadow;
         tw_ff       <= nxt_tw;
         cfg_ff      <= nxt_cfg;
         sig_i_ff    <= nxt_sig_i;
         sig_q_ff    <= nxt_sig_q;
         scnt_ff     <= nxt_scnt;
         rd_ff       <= acc.rd ? nxt_rd : rd_ff;
         rdv_ff      <= acc.rd;
         st_seen_ff  <= nxt_st_seen;
         hp_seen_ff  <= nxt_hp_seen;
         st_state_ff <= nxt_st_state;
         hp_state_ff <= nxt_hp_state;
         st_cnt_ff   <= nxt_st_cnt;
         hp_cnt_ff   <= nxt_hp_cnt;
         stp_ff      <= nxt_stp;
         rap_ff      <= nxt_rap;
         hpp_ff      <= nxt_hpp;
         clp_ff      <= nxt_clp;
      end
   end

   // coefficient storage has no reset; contents are loaded by software
   always_ff @(posedge clk) begin
      if (wr && acc.addr <= 8'h7f) begin
         cram[cram_idx] <= acc.wdata;
      end
      coef_ff <= cram[coef_rd_addr];
   end

   // ********************************************************************
   // outputs
   // ********************************************************************
   assign rd_data         = rd_ff;
   assign rd_valid        = rdv_ff;
   assign coef_rd_data    = coef_ff;
   assign cfg             = cfg_ff;
   assign tuning_word     = tw_ff;
   assign channel_sleep   = sleep_ff;
   assign start_pulse     = stp_ff;
   assign realign_pulse   = rap_ff;
   assign hop_pulse       = hpp_ff;
   assign clear_acc_pulse = clp_ff;
   assign scale_now = li_s2_ff ? cfg_ff.rs_scale[RSC_ACT_L +: 5]
                               : cfg_ff.rs_scale[4:0];
   assign wide_samples = cfg_ff.out_ctrl[OCTL_WIDE];
   assign other_source = cfg_ff.cf_ctrl[FCTL_SRC];

   // ********************************************************************
   // assertions
   // ********************************************************************
   sequence s_hop2;
      hop_trig && hopdel_ff == 16'h0002 ##1 (!hop_trig) [*2];
   endsequence
   property p_start_one;
      @(posedge clk) disable iff (reset)
      start_trig && stdel_ff == 16'h0001 |=> ##1 (start_pulse|realign_pulse);
   endproperty
   a_start_one: assert property (p_start_one)
      else $error("start delay one did not act");
   property p_start_zero;
      @(posedge clk) disable iff (reset)
      start_trig && stdel_ff == 16'h0000 && st_state_ff == CNT_IDLE
      |=> st_state_ff == CNT_IDLE;
   endproperty
   a_start_zero: assert property (p_start_zero)
      else $error("start delay zero armed the counter");
   property p_hop_count;
      @(posedge clk) disable iff (reset)
      s_hop2 |=> hop_pulse && tuning_word == shadow_ff;
   endproperty
   a_hop_count: assert property (p_hop_count)
      else $error("hop did not land after two cycles");
   property p_hop_zero;
      @(posedge clk) disable iff (reset)
      hop_trig && hopdel_ff == 16'h0000 && hp_state_ff == CNT_IDLE
      |=> ##1 !hop_pulse;
   endproperty
   a_hop_zero: assert property (p_hop_zero)
      else $error("hop delay zero still hopped");
   property p_clear;
      @(posedge clk) disable iff (reset)
      hop_pulse |-> clear_acc_pulse == $past(cfg_ff.osc_ctrl[OSC_CLR]);
   endproperty
   a_clear: assert property (p_clear)
      else $error("clear pulse disagrees with control bit");
   property p_pass;
      @(posedge clk) disable iff (reset)
      hit(acc, ADR_TWL) && hopdel_ff == 16'h0001
      |=> tuning_word[15:0] == $past(acc.wdata[15:0]);
   endproperty
   a_pass: assert property (p_pass)
      else $error("write with hop delay one not passed through");
   property p_shadow;
      @(posedge clk) disable iff (reset)
      !hp_fire && !st_fire && hopdel_ff != 16'h0001 |=> $stable(tuning_word);
   endproperty
   a_shadow: assert property (p_shadow)
      else $error("working word changed without wake or hop");
   property p_wake;
      @(posedge clk) disable iff (reset)
      start_pulse |-> !channel_sleep && !realign_pulse;
   endproperty
   a_wake: assert property (p_wake)
      else $error("start did not clear sleep");
   property p_realign;
      @(posedge clk) disable iff (reset)
      st_fire && !sleep_ff |=> realign_pulse && !start_pulse;
   endproperty
   a_realign: assert property (p_realign)
      else $error("running channel restarted instead of realigning");
endmodule
`default_nettype wire

/* File: testbench/dcs_host.sv */
// host model: one-cycle channel accesses
// assumes a rising-edge block, drives on falling edge
`timescale 1ns/1ps
`default_nettype none
module dcs_host
   import dcs_pkg::*;
(
   input  wire logic        clk,
   input  wire logic [19:0] rd_data,
   input  wire logic        rd_valid,
   output var dcs_acc_type  acc
);
   logic [19:0] rd_word;
   initial acc = '0;
   task automatic wr(input logic [7:0] a, input logic [19:0] d);
      @(negedge clk);
      acc = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(negedge clk);
      acc = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
   endtask
   task automatic rd(input logic [7:0] a);
      @(negedge clk);
      acc = '{addr: a, wdata: 20'h0_0000, wr: 1'b0, rd: 1'b1};
      @(negedge clk);
      rd_word = rd_valid ? rd_data : 20'hf_ffff;
      acc.rd = 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// bench for the channel control bank
// assumes the host model drives every channel port access; external sleep and pin writes come from the bench
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import dcs_pkg::*;
;
   logic        clk = 1'b0, reset = 1'b1, lvl = 1'b0;
   logic [15:0] smp = 16'h0000;
   logic        ext_sw = 1'b0, ext_sb = 1'b0, ext_pw = 1'b0, fval = 1'b0;
   logic        cpass = 1'b0;
   logic [2:0]  ext_pb = 3'h0;
   logic [3:0]  spin = 4'h0;
   dcs_cfg_type cf;
   dcs_acc_type acc;
   logic [19:0] rd_data;
   logic        rd_valid, slp, st, ra, hp, clr, wide, oth;
   logic [31:0] tw;
   logic [4:0]  scl;
   int          fails = 0, checks = 0, n;
   initial forever #2.5 clk = ~clk;
   dcs_host dcs_host_inst (.clk(clk), .rd_data(rd_data),
      .rd_valid(rd_valid), .acc(acc));
   dcs_channel dcs_channel_inst (.clk(clk), .reset(reset), .acc(acc),
      .rd_data(rd_data), .rd_valid(rd_valid), .ext_sleep_wr(ext_sw),
      .ext_sleep_bit(ext_sb), .ext_pin_wr(ext_pw),
      .ext_pin_bits(ext_pb), .sync_pin(spin), .level_pin(lvl),
      .filt_i(smp), .filt_q(~smp), .filt_valid(fval),
      .cram_pass(cpass), .dram_pass(1'b0),
      .coef_rd_addr(8'h00), .coef_rd_data(), .cfg(cf),
      .tuning_word(tw), .channel_sleep(slp), .start_pulse(st),
      .realign_pulse(ra), .hop_pulse(hp), .clear_acc_pulse(clr),
      .scale_now(scl), .wide_samples(wide), .other_source(oth));
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   // bounded wait for a pulse, n counts edges since trigger
   // must set: running out of the bound ends the run as a failure
   task automatic wait_p(input int s, input bit must);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (((s == 0) ? st : (s == 1) ? ra : hp) !== 1'b1 && n < 20);
      if (must && n >= 20) begin
         fails++;
         $display("[ERR] pulse %0d exp 1 got 0", s);
         end_of_test();
      end
   endtask
   task automatic t_start();
      chk("sleep", 1, slp);
      dcs_host_inst.wr(ADR_TWL, 20'h0_1234);
      dcs_host_inst.wr(ADR_TWH, 20'h0_abcd);
      dcs_host_inst.wr(ADR_START, 20'h0_0003);
      dcs_host_inst.wr(ADR_SOFT, 20'h0_0001);
      wait_p(0, 1);
      chk("start_n", 3, n);
      chk("awake", 0, slp);
      chk("tw", 32'habcd_1234, tw);
      dcs_host_inst.rd(ADR_START);
      chk("start_rd", 3, dcs_host_inst.rd_word);
      $display("start test done");
   endtask
   task automatic t_realign();
      dcs_host_inst.wr(ADR_START, 20'h0_0001);
      dcs_host_inst.wr(ADR_SOFT, 20'h0_0001);
      wait_p(1, 1);
      chk("realign_n", 1, n);
      dcs_host_inst.wr(ADR_START, 20'h0_0000);
      dcs_host_inst.wr(ADR_SOFT, 20'h0_0001);
      wait_p(1, 0);
      chk("ignored_n", 20, n);
      $display("realign test done");
   endtask
   task automatic t_hop();
      dcs_host_inst.wr(ADR_OSC, 20'h0_0008);
      dcs_host_inst.wr(ADR_HOP, 20'h0_0002);
      dcs_host_inst.wr(ADR_TWL, 20'h0_5555);
      chk("tw_held", 32'habcd_1234, tw);
      dcs_host_inst.wr(ADR_SOFT, 20'h0_0002);
      wait_p(2, 1);
      chk("hop_n", 2, n);
      chk("clr", 1, clr);
      chk("tw_hop", 32'habcd_5555, tw);
      dcs_host_inst.wr(ADR_HOP, 20'h0_0000);
      dcs_host_inst.wr(ADR_SOFT, 20'h0_0002);
      wait_p(2, 0);
      chk("hop_off_n", 20, n);
      chk("tw_off", 32'habcd_5555, tw);
      dcs_host_inst.wr(ADR_HOP, 20'h0_0001);
      dcs_host_inst.wr(ADR_TWH, 20'h0_0042);
      chk("tw_now", 32'h0042_5555, tw);
      dcs_host_inst.wr(ADR_TWL, 20'h0_0077);
      chk("tw_low", 32'h0042_0077, tw);
      $display("hop test done");
   endtask
   task automatic t_fields();
      dcs_host_inst.wr(ADR_RSCL, 20'h0_02aa);
      chk("scl_lo", 5'h0a, scl);
      lvl = 1'b1;
      repeat (4) @(negedge clk);
      chk("scl_hi", 5'h15, scl);
      dcs_host_inst.wr(ADR_OCTL, 20'h0_0020);
      chk("wide", 1, wide);
      dcs_host_inst.wr(ADR_FCTL, 20'h0_0200);
      chk("other", 1, oth);
      $display("field test done");
   endtask
   task automatic t_pins();
      @(negedge clk);
      ext_pb = 3'h5;
      ext_pw = 1'b1;
      @(negedge clk);
      ext_pw = 1'b0;
      dcs_host_inst.wr(ADR_OSC, 20'h0_0100);
      dcs_host_inst.wr(ADR_START, 20'h0_0001);
      spin = 4'h1;
      wait_p(1, 0);
      chk("pin_a_n", 20, n);
      spin = 4'h5;
      wait_p(1, 1);
      chk("pin_c_n", 4, n);
      spin = 4'h1;
      repeat (4) @(negedge clk);
      spin = 4'h5;
      wait_p(1, 0);
      chk("first_n", 20, n);
      spin = 4'h0;
      $display("pin test done");
   endtask
   task automatic t_sleep();
      @(negedge clk);
      ext_sb = 1'b1;
      ext_sw = 1'b1;
      @(negedge clk);
      ext_sw = 1'b0;
      chk("ext_sleep", 1, slp);
      dcs_host_inst.wr(ADR_SLEEP, 20'h0_0000);
      dcs_host_inst.rd(ADR_SLEEP);
      chk("sleep_rd", 0, dcs_host_inst.rd_word);
      dcs_host_inst.wr(ADR_SLEEP, 20'h0_0001);
      dcs_host_inst.wr(ADR_SOFT, 20'h0_0001);
      wait_p(0, 1);
      chk("wake_n", 1, n);
      chk("awake2", 0, slp);
      $display("sleep test done");
   endtask
   task automatic t_sig();
      dcs_host_inst.wr(ADR_OCTL, 20'h0_0200);
      smp = 16'h1234;
      fval = 1'b1;
      @(negedge clk);
      fval = 1'b0;
      dcs_host_inst.rd(ADR_SIGQ);
      chk("sig_q", 16'hedcb, dcs_host_inst.rd_word);
      dcs_host_inst.wr(ADR_OCTL, 20'h0_0000);
      dcs_host_inst.wr(ADR_SCNT, 20'h0_0002);
      fval = 1'b1;
      repeat (3) @(negedge clk);
      fval = 1'b0;
      dcs_host_inst.rd(ADR_SCNT);
      chk("scnt", 0, dcs_host_inst.rd_word);
      dcs_host_inst.rd(ADR_SIGI);
      chk("sig_i", 16'h7e8c, dcs_host_inst.rd_word);
      cpass = 1'b1;
      dcs_host_inst.wr(ADR_MBST, 20'h0_0001);
      dcs_host_inst.rd(ADR_MBST);
      chk("mbist", 3, dcs_host_inst.rd_word);
      dcs_host_inst.wr(ADR_OSC, 20'h0_0047);
      chk("osc", 9'h047, cf.osc_ctrl);
      dcs_host_inst.wr(ADR_FCTL, 20'h0_0010);
      chk("fmt", 2'h1, cf.cf_ctrl[5:4]);
      $display("signature test done");
   endtask
   task automatic end_of_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(negedge clk);
      reset = 1'b0;
      t_start();
      t_realign();
      t_hop();
      t_fields();
      t_pins();
      t_sleep();
      t_sig();
      end_of_test();
   end
endmodule
`default_nettype wire
